// [uil_pkg.sv]
/*
  Shared constants of the USB device port interrupt logic: register
  offsets, bit positions, field masks, reset values and timing counts.
  Assumes a 200 MHz peripheral clock and 32-bit APB data.
*/
package uil_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Clock and timing.

  localparam int unsigned CLK_MHZ       = 200;
  // Bus idle time before suspend, in microseconds (3 ms).
  localparam int unsigned SUSP_IDLE_US  = 3000;
  localparam int unsigned SUSP_IDLE_CYC = SUSP_IDLE_US * CLK_MHZ;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on APB.

  localparam logic [7:0] OFS_CTRL    = 8'h04;
  localparam logic [7:0] OFS_ENABLE  = 8'h10;
  localparam logic [7:0] OFS_DISABLE = 8'h14;
  localparam logic [7:0] OFS_MASK    = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;
  localparam logic [7:0] OFS_CLEAR   = 8'h20;

  //////////////////////////////////////////////////////////////////////////////
  // Bit positions in the enable, disable, mask, status and clear registers; BIT_RMWUP is in the control register.

  localparam int unsigned BIT_EP0   = 0;
  localparam int unsigned BIT_SUSP  = 8;
  localparam int unsigned BIT_RSM   = 9;
  localparam int unsigned BIT_EXT   = 10;
  localparam int unsigned BIT_SOF   = 11;
  localparam int unsigned BIT_BRST  = 12;
  localparam int unsigned BIT_WAKE  = 13;
  localparam int unsigned BIT_RMWUP = 0;

  // Endpoint flag layout: five flags per endpoint, four endpoints.
  localparam int unsigned EP_COUNT  = 4;
  localparam int unsigned EP_FLAGS  = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Field masks and reset values.

  localparam logic [31:0] MASK_BITS = 32'h0000_2F0F;
  localparam logic [31:0] STAT_BITS = 32'h0000_3F0F;
  localparam logic [31:0] CLR_BITS  = 32'h0000_3F00;
  localparam logic [31:0] MASK_RST  = 32'h0000_0200;
  localparam logic [31:0] STAT_RST  = 32'h0000_0000;

endpackage : uil_pkg

// [uil_sync.sv]
/*
  Three-stage synchroniser for an asynchronous pin. The output follows
  the pin once the second and third stages agree.
  Assumes the pin may change at any time relative to clk.
*/
`timescale 1ns/1ps
module uil_sync
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Pin and result
  input  wire logic pin,
  output logic      level
);

  typedef struct packed
  {
    logic q1;
    logic q2;
    logic q3;
    logic lvl;
  } uil_sync_type;

  uil_sync_type s_r;
  uil_sync_type s_nxt;

  ////////////////////////////////////////////////////////////////////////////////

  // The first stage is read only by the second stage.
  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.q1 = pin;
    s_nxt.q2 = s_r.q1;
    s_nxt.q3 = s_r.q2;
    if (s_r.q2 == s_r.q3)
    begin
      s_nxt.lvl = s_r.q3;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.lvl;

endmodule : uil_sync

// [uil_top.sv]
/*
  Interrupt logic of a full-speed USB device port: enable, disable,
  mask, status and clear registers behind an APB slave, suspend
  detection, external resume and the interrupt request output.
  Assumes the USB core gives its event strobes on CLK and the remote
  resume pin is asynchronous.
*/
`timescale 1ns/1ps
module uil_top
#(
  parameter int unsigned SUSP_CYC = uil_pkg::SUSP_IDLE_CYC
)
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Events from the USB core
  input  wire logic [19:0] EP_FLAGS,
  input  wire logic        BUS_ACTIVITY,
  input  wire logic        RESUME_DET,
  input  wire logic        HOST_RESET_DET,
  input  wire logic        SOF_DET,
  input  wire logic        BUS_RESET_END,
  // Remote resume pin
  input  wire logic        REMOTE_RESUME,
  // Outputs
  output logic             SEND_RESUME,
  output logic             SUSPENDED,
  output logic             IRQ
);

  localparam logic [19:0] SUSP_LIM = 20'(SUSP_CYC);

  typedef struct packed
  {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
    logic [31:0] mask;
    logic [31:0] stat;
    logic        remote_wakeup_enable;
    logic [19:0] idle_cnt;
    logic        suspended;
    logic        send_rsm;
    logic        irq;
    logic        ext_prev;
  } uil_state_type;

  uil_state_type s_r;
  uil_state_type s_nxt;

  logic        ext_lvl;
  logic        setup;
  logic        access;
  logic        hit;
  logic        ext_rise;
  logic [31:0] ev;
  logic [31:0] clr;
  logic [3:0]  ep_any;

  ////////////////////////////////////////////////////////////////////////////////
  // Remote resume pin synchroniser.

  uil_sync u_sync
  (
    .clk   (CLK),
    .nrst  (NRST),
    .pin   (REMOTE_RESUME),
    .level (ext_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb
  begin
    s_nxt    = s_r;
    setup    = PSEL & ~PENABLE;
    access   = PSEL & PENABLE & s_r.ready & PWRITE;
    ext_rise = ext_lvl & ~s_r.ext_prev;
    ev       = '0;
    clr      = '0;
    ep_any   = '0;

    // Registered answer: ready in the first access cycle, zero wait.
    s_nxt.ready  = setup;
    hit          = (PADDR == uil_pkg::OFS_CTRL) || (PADDR == uil_pkg::OFS_ENABLE) ||
                   (PADDR == uil_pkg::OFS_DISABLE) || (PADDR == uil_pkg::OFS_MASK) ||
                   (PADDR == uil_pkg::OFS_STATUS) || (PADDR == uil_pkg::OFS_CLEAR);
    s_nxt.slverr = setup & ~hit;
    s_nxt.rdata  = '0;
    if (setup && !PWRITE)
    begin
      unique case (PADDR)
        uil_pkg::OFS_MASK   : s_nxt.rdata = s_r.mask & uil_pkg::MASK_BITS;
        uil_pkg::OFS_STATUS : s_nxt.rdata = s_r.stat & uil_pkg::STAT_BITS;
        uil_pkg::OFS_CTRL   : s_nxt.rdata[uil_pkg::BIT_RMWUP] = s_r.remote_wakeup_enable;
        default             : s_nxt.rdata = '0;
      endcase
    end

    // Writes take effect at the edge that completes the access phase.
    if (access)
    begin
      unique case (PADDR)
        uil_pkg::OFS_ENABLE  : s_nxt.mask = s_r.mask | (PWDATA & uil_pkg::MASK_BITS);
        uil_pkg::OFS_DISABLE : s_nxt.mask = s_r.mask & ~(PWDATA & uil_pkg::MASK_BITS);
        uil_pkg::OFS_CLEAR   : clr = PWDATA & uil_pkg::CLR_BITS;
        uil_pkg::OFS_CTRL    : s_nxt.remote_wakeup_enable = PWDATA[uil_pkg::BIT_RMWUP];
        default              : ;
      endcase
    end

    // Endpoint status follows its flags, so it clears only with them.
    for (int i = 0; i < uil_pkg::EP_COUNT; i++)
    begin
      ep_any[i] = |EP_FLAGS[i*uil_pkg::EP_FLAGS +: uil_pkg::EP_FLAGS];
    end

    // Idle counter: bus activity restarts it and leaves suspend.
    if (BUS_ACTIVITY)
    begin
      s_nxt.idle_cnt  = '0;
      s_nxt.suspended = 1'b0;
    end
    else if (s_r.idle_cnt != SUSP_LIM)
    begin
      s_nxt.idle_cnt = s_r.idle_cnt + 20'h0_0001;
      if (s_r.idle_cnt == SUSP_LIM - 20'h0_0001)
      begin
        ev[uil_pkg::BIT_SUSP] = 1'b1;
        s_nxt.suspended       = 1'b1;
      end
    end

    ev[uil_pkg::BIT_RSM]  = RESUME_DET;
    ev[uil_pkg::BIT_EXT]  = ext_rise & s_r.suspended;
    ev[uil_pkg::BIT_SOF]  = SOF_DET;
    ev[uil_pkg::BIT_BRST] = BUS_RESET_END;
    ev[uil_pkg::BIT_WAKE] = RESUME_DET | HOST_RESET_DET;

    s_nxt.ext_prev = ext_lvl;
    s_nxt.send_rsm = ev[uil_pkg::BIT_EXT] & s_r.remote_wakeup_enable;

    // A new event wins over a clear written in the same cycle.
    s_nxt.stat      = ((s_r.stat & ~clr) | ev) & uil_pkg::STAT_BITS;
    s_nxt.stat[3:0] = ep_any;
    s_nxt.irq       = |(s_nxt.stat & s_nxt.mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      s_r           <= '0;
      s_r.mask      <= uil_pkg::MASK_RST;
      s_r.stat      <= uil_pkg::STAT_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA      = s_r.rdata;
  assign PREADY      = s_r.ready;
  assign PSLVERR     = s_r.slverr;
  assign SEND_RESUME = s_r.send_rsm;
  assign SUSPENDED   = s_r.suspended;
  assign IRQ         = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  AST_IDR_EP0: assert property (
    (access && PADDR == uil_pkg::OFS_DISABLE && PWDATA[uil_pkg::BIT_EP0])
      |=> !s_r.mask[uil_pkg::BIT_EP0])
    else $error("Disable write left endpoint 0 enabled.");

  AST_IDR_WAKE: assert property (
    (access && PADDR == uil_pkg::OFS_DISABLE && PWDATA[uil_pkg::BIT_WAKE])
      |=> !s_r.mask[uil_pkg::BIT_WAKE])
    else $error("Disable write left wakeup enabled.");

  AST_IMR_READ: assert property (
    (setup && !PWRITE && PADDR == uil_pkg::OFS_MASK) |=> (PRDATA == $past(s_r.mask)))
    else $error("Mask read returned wrong value.");

  AST_RSM_RESET: assert property (
    $rose(NRST) |-> (s_r.mask == uil_pkg::MASK_RST))
    else $error("Mask reset value wrong.");

  AST_EP_SET: assert property (
    (|EP_FLAGS[4:0]) |=> s_r.stat[0])
    else $error("Endpoint 0 status not raised.");

  AST_EP_HOLD: assert property (
    (!(|EP_FLAGS[9:5])) |=> !s_r.stat[1])
    else $error("Endpoint 1 status without a flag.");

  AST_SUSPEND: assert property (
    (s_r.idle_cnt == SUSP_LIM - 20'h0_0001 && !BUS_ACTIVITY)
      |=> (s_r.stat[uil_pkg::BIT_SUSP] && SUSPENDED))
    else $error("Suspend not entered after idle time.");

  AST_EXT_RSM: assert property (
    (ext_rise && s_r.suspended) |=> s_r.stat[uil_pkg::BIT_EXT])
    else $error("External resume status not raised.");

  AST_SEND_RSM: assert property (
    (ext_rise && s_r.suspended && s_r.remote_wakeup_enable) |=> SEND_RESUME ##1 !SEND_RESUME)
    else $error("Resume signalling not requested.");

  AST_SOF: assert property (
    SOF_DET |=> s_r.stat[uil_pkg::BIT_SOF])
    else $error("Start of frame status not raised.");

  AST_BRST: assert property (
    BUS_RESET_END |=> s_r.stat[uil_pkg::BIT_BRST])
    else $error("End of bus reset status not raised.");

  AST_WAKE: assert property (
    HOST_RESET_DET |=> s_r.stat[uil_pkg::BIT_WAKE])
    else $error("Wakeup status not raised.");

  AST_IER: assert property (
    (access && PADDR == uil_pkg::OFS_ENABLE && PWDATA[uil_pkg::BIT_SUSP])
      |=> s_r.mask[uil_pkg::BIT_SUSP])
    else $error("Enable write did not set mask.");

  AST_ICR: assert property (
    (access && PADDR == uil_pkg::OFS_CLEAR && PWDATA[uil_pkg::BIT_SOF] && !SOF_DET)
      |=> !s_r.stat[uil_pkg::BIT_SOF])
    else $error("Clear write did not clear status.");

  AST_IRQ: assert property (
    IRQ == (|(s_r.stat & s_r.mask)))
    else $error("Interrupt request disagrees with status and mask.");

  AST_RSVD: assert property (
    (access && PADDR == uil_pkg::OFS_ENABLE) |=> ((s_r.mask & ~uil_pkg::MASK_BITS) == 32'h0000_0000))
    else $error("Reserved mask bit became set.");

endmodule : uil_top

// [uil_host_model.sv]
/*
  Stand-in for the USB host on the far side of the port: it turns
  one-cycle requests from the testbench into bus event strobes.
  Assumes requests are driven on clk and last one cycle each.
*/
`timescale 1ns/1ps
module uil_host_model
(
  // Clock
  input  wire logic       clk,
  // Requests: start of frame, resume, host reset, reset end; bus idle
  input  wire logic [3:0] req,
  input  wire logic       idle,
  // Bus events
  output logic            sof,
  output logic            rsm,
  output logic            hrst,
  output logic            brst_end,
  output logic            act
);
  // The real host keeps the bus busy, so activity only stops on request.
  always_ff @(posedge clk)
  begin
    sof      <= req[0];
    rsm      <= req[1];
    hrst     <= req[2];
    brst_end <= req[3];
    act      <= ~idle;
  end
endmodule : uil_host_model

// [usb_device_interrupt_logic_tb_top.sv]
/*
  Self-checking testbench of the USB device port interrupt logic.
  Assumes a zero-wait APB slave and a shortened suspend count.
*/
`timescale 1ns/1ps
module usb_device_interrupt_logic_tb_top;
  localparam int unsigned SCYC = 50;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic        rres, send_resume, suspended, irq, idle, sof, rsm, hrst, bend, act;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, msk, d;
  logic [19:0] ep_flags;
  logic [3:0]  req;
  int          mismatches, checks_done, seed, i, k;

  uil_top #(.SUSP_CYC(SCYC)) uil_top_i (.CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EP_FLAGS(ep_flags),
    .BUS_ACTIVITY(act), .RESUME_DET(rsm), .HOST_RESET_DET(hrst), .SOF_DET(sof),
    .BUS_RESET_END(bend), .REMOTE_RESUME(rres), .SEND_RESUME(send_resume),
    .SUSPENDED(suspended), .IRQ(irq));
  uil_host_model uil_host_model_i (.clk(clk), .req(req), .idle(idle), .sof(sof),
    .rsm(rsm), .hrst(hrst), .brst_end(bend), .act(act));

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Signals sampled at an edge are the values from before that edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
      mismatches++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rchk

  function automatic logic [3:0] ep_exp(input logic [19:0] f);
    for (int e = 0; e < 4; e++)
      ep_exp[e] = |f[5*e +: 5];
  endfunction : ep_exp

  function automatic logic [31:0] ev_exp(input int n);
    case (n)
      0:       ev_exp = 32'h0000_0800;
      1:       ev_exp = 32'h0000_2200;
      2:       ev_exp = 32'h0000_2000;
      default: ev_exp = 32'h0000_1000;
    endcase
  endfunction : ev_exp

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100_000;
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    seed = 97966;
    {nrst, psel, penable, pwrite, rres, idle} = 6'h00;
    {paddr, pwdata, ep_flags, req} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rchk(uil_pkg::OFS_MASK, uil_pkg::MASK_RST);
    apb(1'h1, uil_pkg::OFS_CLEAR, uil_pkg::CLR_BITS);
    rchk(uil_pkg::OFS_STATUS, 32'h0000_0000);
    msk = uil_pkg::MASK_RST;
    for (i = 0; i < 12; i++)
    begin
      d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_100F : $random(seed);
      apb(1'h1, i[0] ? uil_pkg::OFS_DISABLE : uil_pkg::OFS_ENABLE, d);
      msk = i[0] ? msk & ~d : msk | (d & uil_pkg::MASK_BITS);
      rchk(uil_pkg::OFS_MASK, msk);
    end
    apb(1'h1, uil_pkg::OFS_ENABLE, 32'hFFFF_FFFF);
    msk = uil_pkg::MASK_BITS;
    for (k = 0; k < 4; k++)
    begin
      req <= 4'h1 << k;
      @(posedge clk);
      req <= 4'h0;
      repeat (2) @(posedge clk);
      rchk(uil_pkg::OFS_STATUS, ev_exp(k));
      chk(32'(irq), 32'(|(ev_exp(k) & msk)));
      apb(1'h1, uil_pkg::OFS_CLEAR, uil_pkg::CLR_BITS);
      rchk(uil_pkg::OFS_STATUS, 32'h0000_0000);
    end
    for (i = 0; i < 6; i++)
    begin
      ep_flags <= (i == 0) ? 20'h8_0000 : 20'($random(seed));
      repeat (3) @(posedge clk);
      rchk(uil_pkg::OFS_STATUS, {28'h000_0000, ep_exp(ep_flags)});
      chk(32'(irq), 32'(|ep_exp(ep_flags)));
    end
    ep_flags <= 20'h0_0000;
    repeat (3) @(posedge clk);
    rchk(uil_pkg::OFS_STATUS, 32'h0000_0000);
    apb(1'h0, 8'h40, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    rchk(uil_pkg::OFS_DISABLE, 32'h0000_0000);
    apb(1'h1, uil_pkg::OFS_CTRL, 32'h0000_0001);
    rchk(uil_pkg::OFS_CTRL, 32'h0000_0001);
    idle <= 1'h1;
    repeat (SCYC + 5) @(posedge clk);
    chk(32'(suspended), 32'h0000_0001);
    rchk(uil_pkg::OFS_STATUS, 32'h0000_0100);
    rres <= 1'h1;
    i = 0;
    while (send_resume !== 1'h1 && i < 20)
    begin
      @(posedge clk);
      i++;
    end
    chk(32'(send_resume), 32'h0000_0001);
    rchk(uil_pkg::OFS_STATUS, 32'h0000_0500);
    // A remote resume edge outside suspend must leave status alone.
    idle <= 1'h0;
    rres <= 1'h0;
    apb(1'h1, uil_pkg::OFS_CLEAR, uil_pkg::CLR_BITS);
    rres <= 1'h1;
    repeat (10) @(posedge clk);
    rchk(uil_pkg::OFS_STATUS, 32'h0000_0000);
    chk(32'(suspended), 32'h0000_0000);
    tally_and_finish();
  end
endmodule : usb_device_interrupt_logic_tb_top
